// >>> hdl/mic_defines.svh
// offsets, field positions, reset values and timing counts of the interrupt block
`ifndef MIC_DEFINES_SVH
`define MIC_DEFINES_SVH
`define MIC_ADDR_W 8
// register indices as printed; byte address is four times the index
`define MIC_IDX_IRQ_CONTROL 8'h0B
`define MIC_IDX_PERIPH_FLAGS 8'h0C
`define MIC_IDX_PERIPH_ENABLES 8'h8C
`define MIC_IDX_OPTION 8'h81
`define MIC_IDX_CORE_CMD 8'hF0
`define MIC_IDX_VECTOR 8'hF1
`define MIC_IDX_IRQ_STATUS 8'hF2
`define MIC_IDX_IRQ_MASK 8'hF3
// irq_control_reg fields
`define MIC_BIT_GIE 7
`define MIC_BIT_PERIPHERAL_IRQ_ENABLE 6
`define MIC_BIT_TIMER_OVERFLOW_IRQ_ENABLE 5
`define MIC_BIT_EXTIE 4
`define MIC_BIT_PCIE 3
`define MIC_BIT_TOF 2
`define MIC_BIT_EXTF 1
`define MIC_BIT_PCF 0
// comparator bits in the peripheral registers
`define MIC_BIT_CMP 6
// edge select in the option register
`define MIC_BIT_EDGE 6
// core command bits
`define MIC_BIT_CMD_RETURN 0
`define MIC_BIT_CMD_GIE_CLR 1
`define MIC_BIT_CMD_WAKE 2
// status event bits
`define MIC_EV_ENTRY 0
`define MIC_EV_RETURN 1
// reset values, entry vector and acknowledge timeout
`define MIC_RST_IRQ_CONTROL 8'h00
`define MIC_RST_OPTION 8'hFF
`define MIC_VECTOR_ADDR 13'h0004
`define MIC_ACK_CYCLES 2
`endif

// >>> hdl/mic_pkg.sv
// types shared by the interrupt block
package mic_pkg;
  typedef enum logic [1:0] {
    MIC_RST_POWER_ON,
    MIC_RST_MASTER_CLEAR,
    MIC_RST_BROWN_OUT,
    MIC_RST_WATCHDOG
  } mic_reset_kind_type;
  typedef enum {
    MIC_IDLE,
    MIC_BLOCKED,
    MIC_VECTOR
  } mic_state_type;
endpackage : mic_pkg

// >>> hdl/mic_sync.sv
// three-stage synchroniser with agreed-change output
`timescale 1ns/1ns
module mic_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] held_q;
  // first stage feeds only the second; held_q keeps the last agreed level
  always_ff @(posedge clk) begin
    if (!resetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      held_q <= '0;
    end else if (ce) begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      held_q <= sync_out;
    end
  end

  // agreed level passes at once, saving a cycle of entry latency
  for (genvar i = 0; i < WIDTH; i++) begin : g_agree
    assign sync_out[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : held_q[i];
  end
endmodule : mic_sync

// >>> hdl/mic_irq_ctrl.sv
// interrupt gathering, masking and vectoring with an avalon-mm register slave
// How it works
// - four sources: pin, timer, port, comparator
// - each source has its own flag
// - flags set regardless of any enable
// - global enable gates every core request
// - clearing a source enable suppresses it
// - every reset clears global enable
// - entry clears enable, vectors to 0004h
// - return instruction sets global enable again
// - pin and port latency three or four
// - cycle after enable clear ignores requests
// - comparator bit six of flag/enable
// - control reset keeps port flag except power-on
// - watchdog wake leaves registers untouched
// - edge select picks pin rising or falling
`timescale 1ns/1ns
`include "mic_defines.svh"
module mic_irq_ctrl (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire mic_pkg::mic_reset_kind_type reset_kind,
  input wire logic ext_irq_pin,
  input wire logic [3:0] port_change_pins,
  input wire logic timer_zero_overflow,
  input wire logic comparator_event,
  input wire logic core_return,
  input wire logic core_gie_clear,
  input wire logic core_wake,
  input wire logic core_ack,
  output logic core_irq_req,
  output logic core_nop,
  output logic core_push,
  output logic [12:0] core_vector,
  output logic irq,
  input wire logic [`MIC_ADDR_W+1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  import mic_pkg::*;

  logic [7:0] ctrl_q, ctrl_d;
  logic pflag_q, pflag_d;
  logic pen_q;
  logic [7:0] option_q;
  logic [1:0] stat_q, stat_d;
  logic [1:0] mask_q;
  mic_state_type state_q;
  logic ext_s, ext_prev_q;
  logic [3:0] port_s, port_prev_q;
  logic [1:0] ack_cnt_q;
  logic done_q;

  // pin and port inputs cross into the instruction clock
  // synchronise async events
  mic_sync #(.WIDTH(5)) u_sync (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .async_in({port_change_pins, ext_irq_pin}),
    .sync_out({port_s, ext_s})
  );

  // bus decode; address is byte address, index in bits above two
  wire [`MIC_ADDR_W-1:0] idx = avs_address[`MIC_ADDR_W+1:2];
  wire acc = (avs_read | avs_write) & ~done_q;
  // writes land at the edge where waitrequest is seen low
  wire wr = avs_write & done_q & ce & avs_byteenable[0];
  wire wr_ctrl = wr & (idx == `MIC_IDX_IRQ_CONTROL);
  wire wr_pflag = wr & (idx == `MIC_IDX_PERIPH_FLAGS);
  wire wr_pen = wr & (idx == `MIC_IDX_PERIPH_ENABLES);
  wire wr_opt = wr & (idx == `MIC_IDX_OPTION);
  wire wr_stat = wr & (idx == `MIC_IDX_IRQ_STATUS);
  wire wr_mask = wr & (idx == `MIC_IDX_IRQ_MASK);
  wire [7:0] wd = avs_writedata[7:0];

  // edge detection on settled levels
  // edge select for pin
  wire edge_rise = option_q[`MIC_BIT_EDGE];
  wire ext_ev = edge_rise ? (ext_s & ~ext_prev_q) : (~ext_s & ext_prev_q);
  wire port_ev = |(port_s ^ port_prev_q);

  wire [3:0] src_ev = {comparator_event, timer_zero_overflow, ext_ev, port_ev};

  // request gating; the comparator needs the peripheral enable too
  // events count in the cycle they arrive, keeping latency short
  wire [2:0] core_flag = {ctrl_q[`MIC_BIT_TOF] | src_ev[2],
                          ctrl_q[`MIC_BIT_EXTF] | src_ev[1],
                          ctrl_q[`MIC_BIT_PCF] | src_ev[0]};
  wire core_src = (ctrl_q[`MIC_BIT_TIMER_OVERFLOW_IRQ_ENABLE] & core_flag[2])
                | (ctrl_q[`MIC_BIT_EXTIE] & core_flag[1])
                | (ctrl_q[`MIC_BIT_PCIE] & core_flag[0]);
  wire cmp_src = (pflag_q | src_ev[3]) & pen_q & ctrl_q[`MIC_BIT_PERIPHERAL_IRQ_ENABLE];
  wire pending = ctrl_q[`MIC_BIT_GIE] & (core_src | cmp_src);

  // entry happens when idle and a request is pending, not in a blocked slot
  wire take = (state_q == MIC_IDLE) & pending & ~core_gie_clear;
  wire wake_only = core_wake;

  // next flag and enable values; event set wins over software write
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_ctrl) begin
      ctrl_d = wd;
    end
    if (src_ev[1]) begin
      ctrl_d[`MIC_BIT_EXTF] = 1'b1;
    end
    if (src_ev[2]) begin
      ctrl_d[`MIC_BIT_TOF] = 1'b1;
    end
    if (src_ev[0]) begin
      ctrl_d[`MIC_BIT_PCF] = 1'b1;
    end
    if (core_gie_clear) begin
      ctrl_d[`MIC_BIT_GIE] = 1'b0;
    end
    if (core_return) begin
      ctrl_d[`MIC_BIT_GIE] = 1'b1;
    end
    if (take) begin
      ctrl_d[`MIC_BIT_GIE] = 1'b0;
    end
    pflag_d = wr_pflag ? wd[`MIC_BIT_CMP] : pflag_q;
    if (src_ev[3]) begin
      pflag_d = 1'b1;
    end
    // sticky status, write-one-to-clear, set wins
    stat_d = stat_q;
    if (wr_stat) begin
      stat_d = stat_q & ~wd[1:0];
    end
    if (take) begin
      stat_d[`MIC_EV_ENTRY] = 1'b1;
    end
    if (core_return) begin
      stat_d[`MIC_EV_RETURN] = 1'b1;
    end
  end

  // interrupt control register; reset kind decides the port flag
  // port flag kept on warm reset
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ctrl_q <= `MIC_RST_IRQ_CONTROL;
      // warm resets leave the port flag as it was
      if (reset_kind != MIC_RST_POWER_ON) begin
        ctrl_q[`MIC_BIT_PCF] <= ctrl_q[`MIC_BIT_PCF];
      end
    end else if (ce & ~wake_only) begin
      ctrl_q <= ctrl_d;
    end
  end

  // peripheral flag, enable, option, mask
  // comparator at bit six
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pflag_q <= 1'b0;
      pen_q <= 1'b0;
      option_q <= `MIC_RST_OPTION;
      mask_q <= 2'h0;
      stat_q <= 2'h0;
    end else if (ce & ~wake_only) begin
      pflag_q <= pflag_d;
      stat_q <= stat_d;
      if (wr_pen) begin
        pen_q <= wd[`MIC_BIT_CMP];
      end
      if (wr_opt) begin
        option_q <= wd;
      end
      if (wr_mask) begin
        mask_q <= wd[1:0];
      end
    end
  end

  // edge history
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ext_prev_q <= 1'b0;
      port_prev_q <= 4'h0;
    end else if (ce) begin
      ext_prev_q <= ext_s;
      port_prev_q <= port_s;
    end
  end

  // vectoring sequence towards the core
  // entry one edge after the event
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_q <= MIC_IDLE;
      core_irq_req <= 1'b0;
      core_nop <= 1'b0;
      core_push <= 1'b0;
      core_vector <= 13'h0000;
      ack_cnt_q <= 2'h0;
    end else if (ce) begin
      core_push <= 1'b0;
      core_nop <= 1'b0;
      case (state_q)
        MIC_IDLE: begin
          if (core_gie_clear) begin
            state_q <= MIC_BLOCKED;
            core_nop <= 1'b1;
          end else if (take) begin
            state_q <= MIC_VECTOR;
            core_irq_req <= 1'b1;
            core_push <= 1'b1;
            core_vector <= `MIC_VECTOR_ADDR;
            ack_cnt_q <= 2'h0;
          end
        end
        MIC_BLOCKED: begin
          state_q <= MIC_IDLE;
        end
        MIC_VECTOR: begin
          if (core_ack || ack_cnt_q == 2'(`MIC_ACK_CYCLES)) begin
            state_q <= MIC_IDLE;
            core_irq_req <= 1'b0;
          end else begin
            ack_cnt_q <= ack_cnt_q + 2'h1;
          end
        end
        default: begin
          state_q <= MIC_IDLE;
        end
      endcase
    end
  end

  // read mux
  wire [7:0] rd_mux =
    (idx == `MIC_IDX_IRQ_CONTROL) ? ctrl_q :
    (idx == `MIC_IDX_PERIPH_FLAGS) ? {1'b0, pflag_q, 6'h00} :
    (idx == `MIC_IDX_PERIPH_ENABLES) ? {1'b0, pen_q, 6'h00} :
    (idx == `MIC_IDX_OPTION) ? option_q :
    (idx == `MIC_IDX_VECTOR) ? core_vector[7:0] :
    (idx == `MIC_IDX_IRQ_STATUS) ? {6'h00, stat_q} :
    (idx == `MIC_IDX_IRQ_MASK) ? {6'h00, mask_q} : 8'h00;

  // one wait cycle, then answer; done_q drops the request for one cycle
  always_ff @(posedge clk) begin
    if (!resetn) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
      done_q <= 1'b0;
      irq <= 1'b0;
    end else if (ce) begin
      irq <= |(stat_d & mask_q);
      done_q <= acc;
      avs_waitrequest <= ~acc;
      if (acc & avs_read) begin
        avs_readdata <= {24'h000000, rd_mux};
      end
    end
  end

  // entry must raise the request with the vector and drop enable
  property entry_p;
    @(posedge clk) disable iff (!resetn)
      (ce && take) |=> (core_irq_req && core_vector == 13'h0004
                        && !ctrl_q[7]);
  endproperty
  entry_vec_a: assert property (entry_p) else $error("entry vector wrong");

  return_gie_a: assert property (@(posedge clk) disable iff (!resetn)
    (ce && core_return && !take && !wake_only) |=> ctrl_q[7])
    else $error("return did not set enable");

  gate_off_a: assert property (@(posedge clk) disable iff (!resetn)
    (!ctrl_q[7]) |-> !take)
    else $error("request taken while disabled");

  blocked_slot_a: assert property (@(posedge clk) disable iff (!resetn)
    (ce && core_gie_clear && state_q == MIC_IDLE) |=> core_nop)
    else $error("no nop after enable clear");

  flag_set_a: assert property (@(posedge clk) disable iff (!resetn)
    (ce && !wake_only && timer_zero_overflow) |=> ctrl_q[2])
    else $error("timer flag not set");

  cmp_flag_a: assert property (@(posedge clk) disable iff (!resetn)
    (ce && !wake_only && comparator_event) |=> pflag_q)
    else $error("comparator flag not set");

  cmp_gate_a: assert property (@(posedge clk) disable iff (!resetn)
    (!pen_q && !core_src) |-> !pending)
    else $error("comparator request ungated");

  wake_hold_a: assert property (@(posedge clk) disable iff (!resetn)
    (ce && wake_only) |=> $stable(ctrl_q))
    else $error("wake changed control");

  reset_gie_a: assert property (@(posedge clk)
    (!resetn) |=> !ctrl_q[7])
    else $error("enable survived reset");
endmodule : mic_irq_ctrl

// >>> testbench/mic_core_model.sv
// behavioural fetch sequencer that acknowledges vector entries
`timescale 1ns/1ns
module mic_core_model (
  input wire logic clk,
  input wire logic resetn,
  input wire logic core_push,
  input wire logic slow,
  output logic core_ack
);
  int wait_q;
  // vector taken
  // ack one or two cycles after the push is seen; request drops two cycles after that, so the slow ack rises only as the request drops
  always @(posedge clk) begin
    core_ack <= 1'b0;
    if (!resetn) begin
      wait_q = 0;
    end else if (core_push === 1'b1) begin
      wait_q = slow ? 2 : 1;
    end else if (wait_q > 0) begin
      wait_q--;
      if (wait_q == 0) core_ack <= 1'b1;
    end
  end
endmodule : mic_core_model

// >>> testbench/tb.sv
// self-checking bench for the interrupt block
`timescale 1ns/1ns
`include "mic_defines.svh"
module tb;
  import mic_pkg::*;
  localparam logic [9:0] A_CTL = {`MIC_IDX_IRQ_CONTROL, 2'b00};
  localparam logic [9:0] A_FLG = {`MIC_IDX_PERIPH_FLAGS, 2'b00};
  localparam logic [9:0] A_ENA = {`MIC_IDX_PERIPH_ENABLES, 2'b00};
  localparam logic [9:0] A_OPT = {`MIC_IDX_OPTION, 2'b00};
  localparam logic [9:0] A_STS = {`MIC_IDX_IRQ_STATUS, 2'b00};
  localparam logic [9:0] A_MSK = {`MIC_IDX_IRQ_MASK, 2'b00};
  logic clk = 0, resetn = 0, ext_irq_pin = 0, tov = 0, cmp = 0, slow = 0;
  logic core_return = 0, core_gie_clear = 0, core_wake = 0, core_ack;
  logic core_irq_req, core_nop, core_push, irq, avs_read = 0, avs_write = 0, avs_waitrequest;
  logic [3:0] port_pins = 4'h0;
  logic [12:0] core_vector;
  logic [9:0] avs_address = 10'h000;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  mic_reset_kind_type reset_kind = MIC_RST_POWER_ON;
  int failures = 0, cmp_count = 0, ticks = 0, n, m_ctl, nop_seen = 0, req_seen = 0;
  mic_irq_ctrl dut (.clk(clk), .resetn(resetn), .ce(1'b1), .reset_kind(reset_kind),
    .ext_irq_pin(ext_irq_pin), .port_change_pins(port_pins), .timer_zero_overflow(tov),
    .comparator_event(cmp), .core_return(core_return), .core_gie_clear(core_gie_clear),
    .core_wake(core_wake), .core_ack(core_ack), .core_irq_req(core_irq_req),
    .core_nop(core_nop), .core_push(core_push), .core_vector(core_vector), .irq(irq),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  mic_core_model core (.clk(clk), .resetn(resetn), .core_push(core_push), .slow(slow),
    .core_ack(core_ack));
  initial begin
    forever #5 clk = ~clk;
  end
  // sticky monitors; timeout counts as a mismatch
  always @(posedge clk) begin
    ticks++;
    if (core_nop === 1'b1) nop_seen = 1;
    if (core_irq_req === 1'b1) req_seen = 1;
    if (ticks == 20000) begin
      failures++;
      complete_run();
    end
  end
  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  // request held until waitrequest is sampled low at an edge
  task avs(input logic w, input logic [9:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : avs
  task rd_chk(input string name, input logic [9:0] a, input logic [31:0] exp);
    avs(1'b0, a, 32'h0);
    chk(name, q, exp);
  endtask : rd_chk
  task wait_push;
    n = 0;
    while (core_push !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask : wait_push
  task do_reset(input mic_reset_kind_type k);
    @(posedge clk);
    resetn <= 1'b0;
    reset_kind <= k;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
  endtask : do_reset
  task complete_run;
    $display("checks %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run
  initial begin
    n = $urandom(32'hA254);
    do_reset(MIC_RST_POWER_ON);
    rd_chk("ctl_rst", A_CTL, 32'h0);
    rd_chk("flg_rst", A_FLG, 32'h0);
    rd_chk("ena_rst", A_ENA, 32'h0);
    rd_chk("opt_rst", A_OPT, 32'hFF);
    rd_chk("unmapped", 10'h100, 32'h0);
    // flags rise with every enable off
    @(posedge clk);
    tov <= 1'b1;
    cmp <= 1'b1;
    @(posedge clk);
    tov <= 1'b0;
    cmp <= 1'b0;
    repeat (3) @(posedge clk);
    rd_chk("ctl_tof", A_CTL, 32'h04);
    rd_chk("flg_cmp", A_FLG, 32'h40);
    avs(1'b1, A_ENA, 32'h40);
    avs(1'b1, A_CTL, 32'h80);
    repeat (4) @(posedge clk);
    chk("no_req_peripheral_irq_enable", req_seen, 0);
    avs(1'b1, A_CTL, 32'hC0);
    wait_push();
    chk("vector", core_vector, 13'h0004);
    rd_chk("gie_clr", A_CTL, 32'h40);
    avs(1'b1, A_FLG, 32'h0);
    @(posedge clk);
    core_return <= 1'b1;
    @(posedge clk);
    core_return <= 1'b0;
    rd_chk("gie_set", A_CTL, 32'hC0);
    avs(1'b1, A_CTL, 32'h0);
    // rising then falling edge select
    for (int e = 1; e >= 0; e--) begin
      slow <= e[0];
      avs(1'b1, A_OPT, e ? 32'h40 : 32'h0);
      avs(1'b1, A_CTL, 32'h90);
      @(posedge clk);
      ext_irq_pin <= e[0];
      wait_push();
      chk("pin_latency", n >= 3 && n <= 4, 1);
      rd_chk("pin_flag", A_CTL, 32'h12);
    end
    avs(1'b1, A_CTL, 32'h88);
    @(posedge clk);
    port_pins <= port_pins ^ 4'(($urandom % 15) + 1);
    wait_push();
    chk("port_latency", n >= 3 && n <= 4, 1);
    rd_chk("port_flag", A_CTL, 32'h09);
    chk("irq_masked", irq, 1'b0);
    avs(1'b1, A_MSK, 32'h1);
    repeat (2) @(posedge clk);
    chk("irq_unmasked", irq, 1'b1);
    avs(1'b1, A_STS, 32'h3);
    repeat (2) @(posedge clk);
    chk("irq_cleared", irq, 1'b0);
    // enable cleared as the timer request falls due
    avs(1'b1, A_CTL, 32'hA0);
    @(posedge clk);
    tov <= 1'b1;
    core_gie_clear <= 1'b1;
    @(posedge clk);
    tov <= 1'b0;
    core_gie_clear <= 1'b0;
    m_ctl = 32'hA4;
    wait_push();
    chk("nop_seen", nop_seen, 1);
    chk("ignored", n, 20);
    avs(1'b1, A_CTL, m_ctl);
    wait_push();
    chk("pending_served", n < 20, 1);
    // wake holds register contents
    core_wake <= 1'b1;
    avs(1'b1, A_CTL, 32'hFF);
    core_wake <= 1'b0;
    rd_chk("wake_hold", A_CTL, m_ctl & 32'h7F);
    avs(1'b1, A_CTL, 32'h01);
    do_reset(MIC_RST_WATCHDOG);
    rd_chk("warm_rst", A_CTL, 32'h01);
    complete_run();
  end
endmodule : tb
